/* rtl/timer_pkg.sv */
// Purpose: Shared constants for the gated timer mode logic and its helpers.
// Assumes: 32-bit AXI4-Lite register window, one aligned word per register.
// Notes: Offsets are byte addresses.
package timer_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 32;

  // Register byte offsets
  localparam logic [7:0] OFFSET_MODE = 8'h00;
  localparam logic [7:0] OFFSET_START = 8'h04;
  localparam logic [7:0] OFFSET_STOP = 8'h08;
  localparam logic [7:0] OFFSET_MODULUS = 8'h0C;
  localparam logic [7:0] OFFSET_COUNT = 8'h10;
  localparam logic [7:0] OFFSET_STATUS = 8'h14;

  // Fields of the timer function select register
  localparam int unsigned FN_LSB = 0;
  localparam int unsigned FN_WIDTH = 3;
  localparam int unsigned PRESCALE_LSB = 3;
  localparam int unsigned PRESCALE_WIDTH = 2;
  localparam int unsigned GATE_POL_BIT = 6;
  localparam int unsigned OUT_POL_BIT = 7;

  // Function codes
  localparam logic [2:0] FN_STOP_LOW = 3'h0;
  localparam logic [2:0] FN_EVENT_COUNT = 3'h1;
  localparam logic [2:0] FN_ACCUMULATE = 3'h2;
  localparam logic [2:0] FN_RESTARTABLE = 3'h3;
  localparam logic [2:0] FN_ONE_SHOT = 3'h4;
  localparam logic [2:0] FN_STOP_HIGH = 3'h7;

  // Prescale codes and half periods in timer input clocks
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV2 = 2'h1;
  localparam logic [1:0] PS_DIV64 = 2'h3;
  localparam logic [5:0] PS_HALF_DIV2 = 6'h01;
  localparam logic [5:0] PS_HALF_DIV64 = 6'h20;

  // Status register bits
  localparam int unsigned STAT_ARMED_BIT = 0;
  localparam int unsigned STAT_VALID_BIT = 1;
  localparam int unsigned STAT_FIRED_BIT = 2;
  localparam int unsigned STAT_GATE_BIT = 3;

  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] MODULUS_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 2;

endpackage : timer_pkg

/* rtl/pin_synchronizer.sv */
// Purpose: Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes: Inputs are slow levels; each bit is synchronised on its own.
// Notes: Only the second stage is read.
`timescale 1ns/1ps
module pin_synchronizer #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_reg; // First stage, may go metastable
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg; // Second stage, safe to use
  logic [WIDTH-1:0] sync_next;

  // Shift the pins through both stages
  always_comb begin
    meta_next = pin_async;
    sync_next = meta_reg;
  end

  // Synchronous active-low reset to a constant
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign pin_sync = sync_reg;

endmodule : pin_synchronizer

/* rtl/clock_prescaler.sv */
// Purpose: Divides the synchronised timer clock input into the internal timer clock.
// Assumes: Input is already synchronised to aclk; divide by 1, 2 or 64.
// Notes: Held high and reset while stopped; tick marks each falling transition.
`timescale 1ns/1ps
module clock_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tin_level,
  input wire logic hold_high,
  input wire logic [1:0] divide_select,
  output logic internal_timer_clock,
  output logic tick
);

  logic tin_prev_reg; // Last sampled input level
  logic tin_prev_next;
  logic [5:0] half_cnt_reg; // Input falls seen in this half period
  logic [5:0] half_cnt_next;
  logic clk_reg; // Internal timer clock level
  logic clk_next;
  logic tick_reg; // One-cycle pulse on the falling transition
  logic tick_next;
  logic tin_fall;
  logic [5:0] half_len;

  // One half period ends every half_len input falls
  always_comb begin
    tin_fall = tin_prev_reg & ~tin_level;
    tin_prev_next = tin_level;
    half_cnt_next = half_cnt_reg;
    clk_next = clk_reg;
    half_len = (divide_select == timer_pkg::PS_DIV64) ? timer_pkg::PS_HALF_DIV64 : timer_pkg::PS_HALF_DIV2;
    if (hold_high) begin
      // Stopped: counter cleared and clock parked high
      half_cnt_next = '0;
      clk_next = 1'b1;
    end else if (divide_select == timer_pkg::PS_DIV1 || divide_select == 2'h2) begin
      // Divide by one just follows the input
      half_cnt_next = '0;
      clk_next = tin_level;
    end else if (tin_fall) begin
      if (half_cnt_reg == half_len - 6'h01) begin
        half_cnt_next = '0;
        clk_next = ~clk_reg;
      end else begin
        half_cnt_next = half_cnt_reg + 6'h01;
      end
    end
    tick_next = clk_reg & ~clk_next;
  end

  // Register the divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tin_prev_reg <= 1'b0;
      half_cnt_reg <= '0;
      clk_reg <= 1'b1;
      tick_reg <= 1'b0;
    end else begin
      tin_prev_reg <= tin_prev_next;
      half_cnt_reg <= half_cnt_next;
      clk_reg <= clk_next;
      tick_reg <= tick_next;
    end
  end

  assign internal_timer_clock = clk_reg;
  assign tick = tick_reg;

endmodule : clock_prescaler

/* rtl/gated_timer_mode_logic.sv */
// Purpose: Mode logic of a 16-bit down counter with gated, event and one-shot modes.
// Assumes: AXI4-Lite slave on aclk; gate and timer clock pins are asynchronous.
// Notes: Function codes 5 and 6 are not built here and behave as stopped.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Function
// - Level-gated start with gate already active
// - One-shot waits for gate edge after start
// - Codes 000/111 stop, clock high, output inactive
// - Event counter ignores gate, counts each tick
// - Event counter output valid until read/stop
// - Event counter reloads at zero, keeps counting
// - Accumulative counts only while gate active
// - Accumulative valid at zero, reloads, continues
// - Restartable reloads and holds while gate inactive
// - Restartable read shows value before gate drop
// - Restartable terminal sets valid and reloads
// - One-shot holds modulus, valid from trigger edge
// - One-shot retrigger reloads modulus before terminal
// - One-shot output inactive at terminal count
// - Retrigger ignored during final internal count
// - One-shot gate edge-sensitive, edge selectable
// - Bit 7 selects output polarity
// - Bit 6 selects gate level or edge
// - Start hands control to gate; stop removes
// - Bits 3-4 select prescale 1, 2, 64
module gated_timer_mode_logic (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_clock_input,
  input wire logic timer_gate_input,
  output logic timer_output
);

  // Reload at zero, else decrement; flag landing on zero
  function automatic logic [16:0] count_step(input logic [15:0] cnt, input logic [15:0] modulus);
    logic [16:0] result;
    result = {1'b0, cnt - 16'h0001};
    if (cnt == 16'h0000) begin
      result = {1'b0, modulus};
    end else if (cnt == 16'h0001) begin
      result[16] = 1'b1;
    end
    return result;
  endfunction : count_step

  // Address map check for the write response; the read path decodes in its own case
  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == timer_pkg::OFFSET_MODE || addr == timer_pkg::OFFSET_START ||
      addr == timer_pkg::OFFSET_STOP || addr == timer_pkg::OFFSET_MODULUS ||
      addr == timer_pkg::OFFSET_COUNT || addr == timer_pkg::OFFSET_STATUS;
  endfunction : is_mapped

  // Bus slave state
  logic aw_got_reg, aw_got_next; // Write address held
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic w_got_reg, w_got_next; // Write data held
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // Timer state
  logic [7:0] mode_reg, mode_next; // Timer function select
  logic [15:0] modulus_reg, modulus_next; // Reload value
  logic [15:0] counter_reg, counter_next; // Working down counter
  logic [15:0] readback_reg, readback_next; // Count seen by software
  logic armed_reg, armed_next; // Started, or gate holds control
  logic fired_reg, fired_next; // One-shot period in progress
  logic valid_reg, valid_next; // Output valid in mode terms
  logic gate_prev_reg, gate_prev_next; // Gate active level, last cycle
  logic out_reg, out_next; // Pin level of the timer output

  // Decoded events and helpers
  logic wr_commit;
  logic rd_take;
  logic wr_mode, wr_start, wr_stop, wr_modulus;
  logic rd_count;
  logic [2:0] fn;
  logic fn_stopped;
  logic gate_act;
  logic gate_edge;
  logic last_count;
  logic [16:0] step;
  logic [1:0] sync_out;
  logic tick;

  // Gate and timer clock pins cross into aclk here
  pin_synchronizer #(
    .WIDTH(2)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_async({timer_gate_input, timer_clock_input}),
    .pin_sync(sync_out)
  );

  // Internal timer clock, parked high on stop codes
  clock_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .tin_level(sync_out[0]),
    .hold_high(fn_stopped),
    .divide_select(mode_reg[timer_pkg::PRESCALE_LSB +: timer_pkg::PRESCALE_WIDTH]),
    .internal_timer_clock(),
    .tick(tick)
  );

  // Handshake outputs
  assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_got_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign timer_output = out_reg;

  // Bus slave: address and data in either order
  always_comb begin
    aw_got_next = aw_got_reg;
    aw_addr_next = aw_addr_reg;
    w_got_next = w_got_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    wr_commit = aw_got_reg & w_got_reg;
    rd_take = s_axi_arvalid & ~rvalid_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_next = 1'b1;
      aw_addr_next = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_commit) begin
      // Both halves present: perform the write and answer
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = is_mapped(aw_addr_reg) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (rd_take) begin
      // Data sampled at acceptance stays stable while held
      rvalid_next = 1'b1;
      rresp_next = timer_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        timer_pkg::OFFSET_MODE: rdata_next = {24'h000000, mode_reg};
        timer_pkg::OFFSET_MODULUS: rdata_next = {16'h0000, modulus_reg};
        timer_pkg::OFFSET_COUNT: rdata_next = {16'h0000, readback_reg};
        timer_pkg::OFFSET_STATUS: begin
          rdata_next = 32'h00000000;
          rdata_next[timer_pkg::STAT_ARMED_BIT] = armed_reg;
          rdata_next[timer_pkg::STAT_VALID_BIT] = valid_reg;
          rdata_next[timer_pkg::STAT_FIRED_BIT] = fired_reg;
          rdata_next[timer_pkg::STAT_GATE_BIT] = gate_act;
        end
        timer_pkg::OFFSET_START, timer_pkg::OFFSET_STOP: rdata_next = 32'h00000000;
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = timer_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // Bus slave registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_got_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= timer_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= timer_pkg::RESP_OKAY;
    end else begin
      aw_got_reg <= aw_got_next;
      aw_addr_reg <= aw_addr_next;
      w_got_reg <= w_got_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Timer mode logic
  always_comb begin
    // Register side effects of the bus
    wr_mode = wr_commit & (aw_addr_reg == timer_pkg::OFFSET_MODE) & w_strb_reg[0];
    wr_start = wr_commit & (aw_addr_reg == timer_pkg::OFFSET_START);
    wr_stop = wr_commit & (aw_addr_reg == timer_pkg::OFFSET_STOP);
    wr_modulus = wr_commit & (aw_addr_reg == timer_pkg::OFFSET_MODULUS);
    rd_count = rd_take & ({s_axi_araddr[7:2], 2'b00} == timer_pkg::OFFSET_COUNT);
    fn = mode_reg[timer_pkg::FN_LSB +: timer_pkg::FN_WIDTH];
    fn_stopped = (fn == timer_pkg::FN_STOP_LOW) || (fn == timer_pkg::FN_STOP_HIGH) || (fn > timer_pkg::FN_ONE_SHOT);
    gate_act = sync_out[1] ^ mode_reg[timer_pkg::GATE_POL_BIT];
    gate_edge = gate_act & ~gate_prev_reg;
    last_count = fired_reg & (counter_reg == 16'h0001);
    step = count_step(counter_reg, modulus_reg);
    mode_next = mode_reg;
    modulus_next = modulus_reg;
    counter_next = counter_reg;
    readback_next = readback_reg;
    armed_next = armed_reg;
    fired_next = fired_reg;
    valid_next = valid_reg;
    gate_prev_next = gate_act;
    // Mode can change any time; software is expected to stop first
    if (wr_mode) begin
      mode_next = w_data_reg[7:0];
    end
    if (wr_modulus) begin
      if (w_strb_reg[0]) begin
        modulus_next[7:0] = w_data_reg[7:0];
      end
      if (w_strb_reg[1]) begin
        modulus_next[15:8] = w_data_reg[15:8];
      end
    end
    // Clear first so a same-cycle terminal count wins
    if (rd_count && fn != timer_pkg::FN_ONE_SHOT) begin
      valid_next = 1'b0;
    end
    if (wr_stop) begin
      armed_next = 1'b0;
      fired_next = 1'b0;
      valid_next = 1'b0;
    end
    if (fn_stopped) begin
      // Stop codes: nothing runs and the output goes inactive
      armed_next = 1'b0;
      fired_next = 1'b0;
      valid_next = 1'b0;
      counter_next = modulus_reg; // Clock high: modulus loads
    end else if (armed_reg) begin
      unique case (fn)
        timer_pkg::FN_EVENT_COUNT: begin
          // Gate plays no part here
          if (tick) begin
            counter_next = step[15:0];
            readback_next = step[15:0];
            if (step[16]) begin
              valid_next = 1'b1;
            end
          end
        end
        timer_pkg::FN_ACCUMULATE: begin
          // Gate inactive simply freezes the count in place
          if (tick && gate_act) begin
            counter_next = step[15:0];
            readback_next = step[15:0];
            if (step[16]) begin
              valid_next = 1'b1;
            end
          end
        end
        timer_pkg::FN_RESTARTABLE: begin
          if (gate_act) begin
            if (tick) begin
              counter_next = step[15:0];
              readback_next = step[15:0];
              if (step[16]) begin
                valid_next = 1'b1;
              end
            end
          end else begin
            // Every aclk cycle with the gate inactive reloads the modulus
            counter_next = modulus_reg;
            // Readback keeps the value reached before the gate dropped
            readback_next = readback_reg;
          end
        end
        default: begin
          // One-shot: trigger on the active edge, ignored during the last count
          if (gate_edge && !last_count) begin
            counter_next = modulus_reg;
            fired_next = 1'b1;
            valid_next = 1'b1;
          end else if (fired_reg && tick) begin
            readback_next = step[15:0];
            counter_next = step[15:0];
            if (step[16]) begin
              counter_next = modulus_reg;
              fired_next = 1'b0;
              valid_next = 1'b0;
            end
          end
        end
      endcase
    end
    // Start acts at the end of the write
    if (wr_start && !fn_stopped) begin
      armed_next = 1'b1;
      if (fn != timer_pkg::FN_EVENT_COUNT) begin
        counter_next = modulus_reg;
        fired_next = 1'b0;
        valid_next = 1'b0;
      end
    end
    // Output pin follows valid through the polarity bit
    out_next = valid_next ? mode_next[timer_pkg::OUT_POL_BIT] : ~mode_next[timer_pkg::OUT_POL_BIT];
  end

  // Timer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= timer_pkg::MODE_RESET;
      modulus_reg <= timer_pkg::MODULUS_RESET;
      counter_reg <= timer_pkg::COUNT_RESET;
      readback_reg <= timer_pkg::COUNT_RESET;
      armed_reg <= 1'b0;
      fired_reg <= 1'b0;
      valid_reg <= 1'b0;
      gate_prev_reg <= 1'b1;
      out_reg <= 1'b1; // Active-low output idles high after reset
    end else begin
      mode_reg <= mode_next;
      modulus_reg <= modulus_next;
      counter_reg <= counter_next;
      readback_reg <= readback_next;
      armed_reg <= armed_next;
      fired_reg <= fired_next;
      valid_reg <= valid_next;
      gate_prev_reg <= gate_prev_next;
      out_reg <= out_next;
    end
  end

endmodule : gated_timer_mode_logic

/* verif/timer_checker_properties.sv */
// Purpose: Port-level checks of the timer mode logic.
// Assumes: Bound into the design; writes commit as bvalid rises.
// Notes: Mode is shadowed from bus traffic, one edge behind the design.
`timescale 1ns/1ps
module timer_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_output
);
  logic [7:0] addr_reg; // Last write address taken
  logic [31:0] data_reg; // Last write data taken
  logic [7:0] mode_reg; // Shadow of the function select register
  logic bv_reg; // Bvalid one cycle ago
  logic [3:0] since_reg; // Cycles since a mode commit, saturating
  logic commit; // First cycle of a write response
  assign commit = s_axi_bvalid && !bv_reg;
  // Shadow state; since_reg hides the one-edge lag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_reg <= 8'h00;
      data_reg <= 32'h0;
      mode_reg <= 8'h00;
      bv_reg <= 1'b0;
      since_reg <= 4'h0;
    end else begin
      bv_reg <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) addr_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) data_reg <= s_axi_wdata;
      if (commit && (addr_reg & 8'hFC) == timer_pkg::OFFSET_MODE) begin
        mode_reg <= data_reg[7:0];
        since_reg <= 4'h0;
      end else if (since_reg != 4'hF) begin
        since_reg <= since_reg + 4'h1;
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  stopped_output_a: assert property (
    (mode_reg[2:0] == 3'h0 || mode_reg[2:0] == 3'h7) && !commit && since_reg > 4'h2 |-> timer_output == !mode_reg[7])
    else $error("output active while stopped");
  stop_write_a: assert property (
    commit && (addr_reg & 8'hFC) == timer_pkg::OFFSET_STOP |-> ##[1:2] timer_output == !mode_reg[7])
    else $error("output active after stop");
  reset_output_a: assert property ($rose(aresetn) |-> timer_output)
    else $error("output active after reset");
endmodule : timer_checker
bind gated_timer_mode_logic timer_checker i_checker (.*);

/* verif/timer_link_model.sv */
// Purpose: Far-side model driving the timer clock and gate pins.
// Assumes: Clock comes in bursts of whole periods; pins change after aclk edges.
// Notes: Clock stands high between bursts; each gate level holds a minimum time.
`timescale 1ns/1ps
module timer_link_model (
  input wire logic aclk,
  input wire logic burst,
  input wire logic [7:0] burst_len,
  input wire logic gate_req,
  output logic busy,
  output logic timer_clock_input,
  output logic timer_gate_input
);
  logic [8:0] left_reg = 9'h000; // Half periods still to send
  logic [1:0] phase_reg = 2'h0; // Cycles within a half period
  logic [5:0] hold_reg = 6'h00; // Time left at the present gate level
  logic clk_reg = 1'b1; // Clock pin level
  logic gate_reg = 1'b0; // Gate pin level
  assign busy = burst || (left_reg != 9'h000);
  assign timer_clock_input = clk_reg;
  assign timer_gate_input = gate_reg;
  // Four aclk cycles a level, above the synchroniser's minimum
  always @(posedge aclk) begin
    if (burst) begin
      left_reg <= {burst_len, 1'b0};
      phase_reg <= 2'h0;
    end else if (left_reg != 9'h000) begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == 2'h3) begin
        left_reg <= left_reg - 9'h001;
        clk_reg <= ~clk_reg;
      end
    end
  end
  // Inactive gate outlasts the internal clock high time
  always @(posedge aclk) begin
    if (hold_reg != 6'h00) begin
      hold_reg <= hold_reg - 6'h01;
    end else if (gate_req != gate_reg) begin
      gate_reg <= gate_req;
      hold_reg <= 6'h28;
    end
  end
endmodule : timer_link_model

/* verif/tb.sv */
// Purpose: Self-checking bench for the timer mode logic.
// Assumes: Random modulus, polarities and prescale from a fixed seed.
// Notes: Bursts are whole periods; prescaler phase is reset.
`timescale 1ns/1ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, ps;
  logic timer_clock_input, timer_gate_input, timer_output, busy;
  logic burst = 1'b0, gate_req = 1'b0, op, gp;
  logic [7:0] burst_len = 8'h01;
  logic [31:0] d;
  int mismatches = 0, check_count = 0, div, m, k;
  integer seed = 32'h852A0FC5;
  gated_timer_mode_logic i_dut (.*);
  timer_link_model i_link (.*);
  always #4 aclk = ~aclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic exp_out(input logic v);
    return v ? op : !op;
  endfunction : exp_out
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic sv(input logic e);
    rd(timer_pkg::OFFSET_STATUS);
    chk(32'(d[timer_pkg::STAT_VALID_BIT]), 32'(e));
    chk(32'(timer_output), 32'(exp_out(e)));
  endtask : sv
  task automatic cnt(input int e);
    rd(timer_pkg::OFFSET_COUNT);
    chk(d, 32'(e));
  endtask : cnt
  task automatic gate(input logic act);
    gate_req <= act ^ gp;
    repeat (60) @(posedge aclk);
  endtask : gate
  task automatic tk(input int n);
    burst_len <= 8'(n * div);
    burst <= 1'b1;
    @(posedge aclk);
    burst <= 1'b0;
    @(posedge aclk);
    for (int i = 0; i < 2000 && busy; i++) @(posedge aclk);
    repeat (8) @(posedge aclk);
  endtask : tk
  task automatic setup(input logic [2:0] fn);
    op = $random(seed);
    gp = $random(seed);
    ps = ($random(seed) & 1) ? timer_pkg::PS_DIV2 : timer_pkg::PS_DIV1;
    div = (ps == timer_pkg::PS_DIV2) ? 2 : 1;
    m = 3 + ($unsigned($random(seed)) % 8);
    k = 1 + ($unsigned($random(seed)) % (m - 1));
    wr(timer_pkg::OFFSET_MODE, 32'h0);
    wr(timer_pkg::OFFSET_MODULUS, 32'(m));
    wr(timer_pkg::OFFSET_MODE, {24'h0, op, gp, 1'b0, ps, fn});
  endtask : setup
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // Watchdog cuts a hang short
  initial begin
    repeat (60000) @(posedge aclk);
    mismatches++;
    results();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(timer_pkg::OFFSET_MODE);
    chk(d, 32'(timer_pkg::MODE_RESET));
    rd(8'h18);
    chk(32'(r), 32'(timer_pkg::RESP_SLVERR));
    for (int i = 0; i < 2; i++) begin
      op = $random(seed);
      wr(timer_pkg::OFFSET_MODE, {24'h0, op, 4'h0, (i == 0) ? timer_pkg::FN_STOP_LOW : timer_pkg::FN_STOP_HIGH});
      wr(timer_pkg::OFFSET_START, 32'h0);
      sv(1'b0);
    end
    repeat (2) begin
      setup(timer_pkg::FN_ACCUMULATE);
      gate(1'b1);
      wr(timer_pkg::OFFSET_START, 32'h0);
      tk(k);
      cnt(m - k);
      gate(1'b0);
      tk(2);
      cnt(m - k);
      gate(1'b1);
      tk(m - k);
      sv(1'b1);
      cnt(0);
      sv(1'b0);
      setup(timer_pkg::FN_RESTARTABLE);
      gate(1'b1);
      wr(timer_pkg::OFFSET_START, 32'h0);
      tk(k);
      gate(1'b0);
      cnt(m - k);
      gate(1'b1);
      tk(1);
      cnt(m - 1);
      tk(m - 1);
      sv(1'b1);
      wr(timer_pkg::OFFSET_STOP, 32'h0);
      sv(1'b0);
      setup(timer_pkg::FN_ONE_SHOT);
      gate(1'b1);
      wr(timer_pkg::OFFSET_START, 32'h0);
      tk(2);
      sv(1'b0);
      gate(1'b0);
      gate(1'b1);
      sv(1'b1);
      tk(m - 2);
      gate(1'b0);
      gate(1'b1);
      tk(m - 1);
      sv(1'b1);
      tk(1);
      sv(1'b0);
      gate(1'b0);
      gate(1'b1);
      tk(m - 1);
      gate(1'b0);
      gate(1'b1);
      tk(1);
      sv(1'b0);
      setup(timer_pkg::FN_EVENT_COUNT);
      gate(1'b0);
      wr(timer_pkg::OFFSET_START, 32'h0);
      tk(m + 1);
      sv(1'b1);
      rd(timer_pkg::OFFSET_COUNT);
      sv(1'b0);
    end
    results();
  end
endmodule : tb
